// *** ssm_pkg.sv ***
package ssm_pkg;
    localparam int SPEED_W = 32;
    localparam int FRAC_W = 16;
    localparam int CLK_HZ = 125000000;
    localparam int SWITCH_TIME_US = 4000;
    localparam int SWITCH_CYCLES = SWITCH_TIME_US * (CLK_HZ / 1000000);
    localparam int RAMP_TIME_MS_DEF = 10000;
    localparam int MAX_SPEED_RPM_DEF = 1500;
    localparam logic [4:0] CFG_RESET = 5'h06;
    localparam int CFG_KEEP = 0;
    localparam int CFG_AUTO_RAMP = 1;
    localparam int CFG_ROUND = 2;
    localparam int CFG_NV_SAVE = 3;
    localparam int CFG_ALWAYS = 4;
    localparam int ROUND_CYCLES = 1024;
    localparam logic [11:0] SRC_ANALOG = 12'h2F3;
    localparam logic [11:0] SRC_FIELDBUS = 12'h802;
    localparam logic [11:0] SRC_POT = 12'h41A;
    localparam logic [11:0] SRC_FIXED = 12'h400;
    localparam logic [3:0] ADDR_CMD_SEL = 4'h0;
    localparam logic [3:0] ADDR_MAIN_SRC = 4'h1;
    localparam logic [3:0] ADDR_EXTRA_SRC = 4'h2;
    localparam logic [3:0] ADDR_CFG = 4'h3;
    localparam logic [3:0] ADDR_RISE = 4'h4;
    localparam logic [3:0] ADDR_FALL = 4'h5;
    localparam logic [3:0] ADDR_START = 4'h6;
    localparam logic [3:0] ADDR_UPPER = 4'h7;
    localparam logic [3:0] ADDR_LOWER = 4'h8;
    localparam logic [3:0] ADDR_MAXSPD = 4'h9;
    localparam logic [3:0] ADDR_BIND = 4'hA;
    localparam logic [3:0] ADDR_STATUS = 4'hB;
    localparam logic [3:0] ADDR_POT = 4'hC;
    localparam logic [3:0] ADDR_MAIN = 4'hD;
    localparam logic [3:0] ADDR_EXTRA = 4'hE;
    localparam logic [3:0] ADDR_SETVAL = 4'hF;
    typedef struct packed {
        logic [SPEED_W-1:0] analog0;
        logic [SPEED_W-1:0] second_process_word;
        logic [SPEED_W-1:0] fixed_setpoint;
        logic [SPEED_W-1:0] setting_value;
    } ssm_sources_type;
    typedef struct packed {
        logic tech_active;
        logic jog_active;
        logic panel_active;
        logic [SPEED_W-1:0] tech_value;
        logic [SPEED_W-1:0] jog_value;
        logic [SPEED_W-1:0] panel_value;
    } ssm_override_type;
    typedef enum logic [1:0] {SSM_IDLE, SSM_SWITCHING} ssm_cds_state_type;
endpackage

// *** ssm_setpoint.sv ***
// Added by the designer: the address map and the APB interface to the registers.
module ssm_setpoint #(
    parameter int SWITCH_CNT = ssm_pkg::SWITCH_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [5:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] bin_in,
    input wire logic motor_on_in,
    input wire logic pulse_enable_in,
    input wire ssm_pkg::ssm_sources_type sources_in,
    input wire ssm_pkg::ssm_override_type override_in,
    output logic [31:0] main_setpoint_out,
    output logic [31:0] extra_setpoint_out,
    output logic [31:0] pot_value_out,
    output logic command_set_out
);
    import ssm_pkg::*;

    logic [7:0] bin_meta;
    logic [7:0] bin_sync;
    logic [11:0] main_setpoint_source;
    logic [11:0] extra_setpoint_source;
    logic [4:0] pot_config_word;
    logic [31:0] pot_rise_time;
    logic [31:0] pot_fall_time;
    logic signed [31:0] pot_start_value;
    logic signed [31:0] pot_upper_bound;
    logic signed [31:0] pot_lower_bound;
    logic [31:0] max_speed_ref;
    logic [2:0] command_set_selector;
    logic [2:0] raise_idx;
    logic [2:0] lower_idx;
    logic [2:0] mode_idx;
    logic raise_bound;
    logic lower_bound_en;
    logic mode_bound;
    logic [31:0] stored_value;
    logic nv_valid;
    logic signed [47:0] pot_acc;
    logic motor_on_d;
    logic [10:0] round_cnt;
    ssm_cds_state_type cds_state;
    logic [31:0] cds_cnt;
    logic cds_target;
    logic pot_raise_cmd;
    logic pot_lower_cmd;
    logic pot_auto_manual_sel;
    logic signed [47:0] next_pot;
    logic signed [47:0] step;
    logic signed [47:0] upper_q;
    logic signed [47:0] lower_q;
    logic wr;

    function automatic logic [31:0] pick(input logic [11:0] src, input logic [31:0] pot);
        case (src)
            SRC_ANALOG: pick = sources_in.analog0;
            SRC_FIELDBUS: pick = sources_in.second_process_word;
            SRC_POT: pick = pot;
            SRC_FIXED: pick = sources_in.fixed_setpoint;
            default: pick = 32'h0;
        endcase
    endfunction

    function automatic logic signed [47:0] rate(input logic [31:0] ramp_ms,
        input logic [31:0] max_rpm);
        logic [63:0] num;
        logic [63:0] den;
        num = {16'h0, max_rpm, 16'h0};
        den = 64'(ramp_ms) * 64'(CLK_HZ / 1000);
        if (den == 64'h0) begin
            rate = 48'sh7FFF_FFFF_FFFF;
        end else begin
            rate = 48'(num / den);
            if (rate == 48'sh0) begin
                rate = 48'sh1;
            end
        end
    endfunction

    assign wr = psel && penable && pwrite;
    assign pot_raise_cmd = raise_bound && bin_sync[raise_idx];
    assign pot_lower_cmd = lower_bound_en && bin_sync[lower_idx];
    assign pot_auto_manual_sel = mode_bound && bin_sync[mode_idx];
    assign upper_q = {pot_upper_bound, 16'h0};
    assign lower_q = {pot_lower_bound, 16'h0};

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bin_meta <= 8'h00;
            bin_sync <= 8'h00;
        end else begin
            bin_meta <= bin_in;
            bin_sync <= bin_meta;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            main_setpoint_source <= SRC_POT;
            extra_setpoint_source <= 12'h000;
            pot_config_word <= CFG_RESET;
            pot_rise_time <= 32'(RAMP_TIME_MS_DEF);
            pot_fall_time <= 32'(RAMP_TIME_MS_DEF);
            pot_start_value <= 32'sh0;
            pot_upper_bound <= 32'sh0;
            pot_lower_bound <= 32'sh0;
            max_speed_ref <= 32'(MAX_SPEED_RPM_DEF);
            command_set_selector <= 3'h0;
            raise_idx <= 3'h0;
            lower_idx <= 3'h0;
            mode_idx <= 3'h0;
            raise_bound <= 1'b0;
            lower_bound_en <= 1'b0;
            mode_bound <= 1'b0;
        end else if (wr) begin
            case (paddr[5:2])
                ADDR_CMD_SEL: command_set_selector <= pwdata[2:0];
                ADDR_MAIN_SRC: main_setpoint_source <= pwdata[11:0];
                ADDR_EXTRA_SRC: extra_setpoint_source <= pwdata[11:0];
                ADDR_CFG: pot_config_word <= pwdata[4:0];
                ADDR_RISE: pot_rise_time <= pwdata;
                ADDR_FALL: pot_fall_time <= pwdata;
                ADDR_START: pot_start_value <= pwdata;
                ADDR_UPPER: pot_upper_bound <= pwdata;
                ADDR_LOWER: pot_lower_bound <= pwdata;
                ADDR_MAXSPD: max_speed_ref <= pwdata;
                ADDR_BIND: begin
                    raise_idx <= pwdata[2:0];
                    raise_bound <= pwdata[3];
                    lower_idx <= pwdata[6:4];
                    lower_bound_en <= pwdata[7];
                    mode_idx <= pwdata[10:8];
                    mode_bound <= pwdata[11];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable && !pwrite) begin
                case (paddr[5:2])
                    ADDR_CMD_SEL: prdata <= {29'h0, command_set_selector};
                    ADDR_MAIN_SRC: prdata <= {20'h0, main_setpoint_source};
                    ADDR_EXTRA_SRC: prdata <= {20'h0, extra_setpoint_source};
                    ADDR_CFG: prdata <= {27'h0, pot_config_word};
                    ADDR_RISE: prdata <= pot_rise_time;
                    ADDR_FALL: prdata <= pot_fall_time;
                    ADDR_START: prdata <= pot_start_value;
                    ADDR_UPPER: prdata <= pot_upper_bound;
                    ADDR_LOWER: prdata <= pot_lower_bound;
                    ADDR_MAXSPD: prdata <= max_speed_ref;
                    ADDR_BIND: prdata <= {20'h0, mode_bound, mode_idx, lower_bound_en,
                        lower_idx, raise_bound, raise_idx};
                    ADDR_STATUS: prdata <= {29'h0, cds_state == SSM_SWITCHING,
                        pot_auto_manual_sel, command_set_out};
                    ADDR_POT: prdata <= pot_acc[47:16];
                    ADDR_MAIN: prdata <= main_setpoint_out;
                    ADDR_EXTRA: prdata <= extra_setpoint_out;
                    default: prdata <= sources_in.setting_value;
                endcase
            end
        end
    end

    // Command set follows the bound selector bit after the switch time
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cds_state <= SSM_IDLE;
            cds_cnt <= 32'h0;
            cds_target <= 1'b0;
            command_set_out <= 1'b0;
        end else begin
            case (cds_state)
                SSM_IDLE: begin
                    if (bin_sync[command_set_selector] != command_set_out) begin
                        cds_target <= bin_sync[command_set_selector];
                        cds_cnt <= 32'h0;
                        cds_state <= SSM_SWITCHING;
                    end
                end
                SSM_SWITCHING: begin
                    if (bin_sync[command_set_selector] != cds_target) begin
                        cds_state <= SSM_IDLE;
                    end else if (cds_cnt >= 32'(SWITCH_CNT - 1)) begin
                        command_set_out <= cds_target;
                        cds_state <= SSM_IDLE;
                    end else begin
                        cds_cnt <= cds_cnt + 32'h1;
                    end
                end
                default: cds_state <= SSM_IDLE;
            endcase
        end
    end

    always_comb begin
        step = 48'sh0;
        next_pot = pot_acc;
        if (pot_raise_cmd && !pot_lower_cmd) begin
            if (pot_auto_manual_sel && !pot_config_word[CFG_AUTO_RAMP]) begin
                next_pot = upper_q;
            end else begin
                step = rate(pot_rise_time, max_speed_ref);
                if (pot_config_word[CFG_ROUND] && round_cnt < 11'(ROUND_CYCLES)) begin
                    step = (step >>> 4) + 48'sh1;
                end
                next_pot = pot_acc + step;
            end
        end else if (pot_lower_cmd && !pot_raise_cmd) begin
            if (pot_auto_manual_sel && !pot_config_word[CFG_AUTO_RAMP]) begin
                next_pot = lower_q;
            end else begin
                step = rate(pot_fall_time, max_speed_ref);
                if (pot_config_word[CFG_ROUND] && round_cnt < 11'(ROUND_CYCLES)) begin
                    step = (step >>> 4) + 48'sh1;
                end
                next_pot = pot_acc - step;
            end
        end
        if (next_pot > upper_q) begin
            next_pot = upper_q;
        end
        if (next_pot < lower_q) begin
            next_pot = lower_q;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pot_acc <= 48'sh0;
            motor_on_d <= 1'b0;
            round_cnt <= 11'h0;
            stored_value <= 32'h0;
        end else begin
            motor_on_d <= motor_on_in;
            if (pot_raise_cmd == pot_lower_cmd) begin
                round_cnt <= 11'h0;
            end else if (round_cnt < 11'(ROUND_CYCLES)) begin
                round_cnt <= round_cnt + 11'h1;
            end
            if (motor_on_in && !motor_on_d) begin
                if (pot_config_word[CFG_KEEP]) begin
                    pot_acc <= {stored_value, 16'h0};
                end else begin
                    pot_acc <= {pot_start_value, 16'h0};
                end
            end else if (pot_config_word[CFG_ALWAYS] || pulse_enable_in) begin
                pot_acc <= next_pot;
            end
            if (!motor_on_in && motor_on_d) begin
                stored_value <= pot_acc[47:16];
            end
            if (wr && paddr[5:2] == ADDR_SETVAL) begin
                pot_acc <= {sources_in.setting_value, 16'h0};
            end
        end
    end

    // Flag nv_valid is set only when the keep option is on too; nothing reads it, and reset clears stored_value
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nv_valid <= 1'b0;
        end else begin
            nv_valid <= pot_config_word[CFG_NV_SAVE] && pot_config_word[CFG_KEEP];
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            main_setpoint_out <= 32'h0;
            extra_setpoint_out <= 32'h0;
            pot_value_out <= 32'h0;
        end else begin
            pot_value_out <= pot_acc[47:16];
            extra_setpoint_out <= pick(extra_setpoint_source, pot_acc[47:16]);
            if (override_in.tech_active) begin
                main_setpoint_out <= override_in.tech_value;
            end else if (override_in.jog_active) begin
                main_setpoint_out <= override_in.jog_value;
            end else if (override_in.panel_active) begin
                main_setpoint_out <= override_in.panel_value;
            end else begin
                main_setpoint_out <= pick(main_setpoint_source, pot_acc[47:16]);
            end
        end
    end
endmodule

// *** ssm_setpoint_properties.sv ***
module ssm_properties #(
    parameter int SWITCH_CNT = ssm_pkg::SWITCH_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [5:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [7:0] bin_in,
    input wire logic motor_on_in,
    input wire logic pulse_enable_in,
    input wire ssm_pkg::ssm_sources_type sources_in,
    input wire ssm_pkg::ssm_override_type override_in,
    input wire logic [31:0] main_setpoint_out,
    input wire logic [31:0] extra_setpoint_out,
    input wire logic [31:0] pot_value_out,
    input wire logic command_set_out
);
    import ssm_pkg::*;
    logic wr;
    logic no_ov;
    logic [2:0] sel;
    logic [11:0] msrc;
    logic [11:0] xsrc;
    logic cfg_all;
    int quiet;
    assign wr = psel && penable && pwrite;
    assign no_ov = !override_in.tech_active && !override_in.jog_active && !override_in.panel_active;
    // Shadow of the registers that steer the outputs
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sel <= 3'h0;
            msrc <= SRC_POT;
            xsrc <= 12'h000;
            cfg_all <= 1'b0;
        end else if (wr) begin
            if (paddr[5:2] == ADDR_CMD_SEL) sel <= pwdata[2:0];
            if (paddr[5:2] == ADDR_MAIN_SRC) msrc <= pwdata[11:0];
            if (paddr[5:2] == ADDR_EXTRA_SRC) xsrc <= pwdata[11:0];
            if (paddr[5:2] == ADDR_CFG) cfg_all <= pwdata[CFG_ALWAYS];
        end
    end
    // Cycles since the selected binary signal last moved or the selector register was written
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) quiet <= 0;
        else if ($changed(bin_in[sel]) || (wr && paddr[5:2] == ADDR_CMD_SEL)) quiet <= 0;
        else if (quiet < 100000) quiet <= quiet + 1;
    end
    cmd_delay_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        $changed(command_set_out) |-> quiet >= SWITCH_CNT) else $error("command set early");
    tech_wins_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        override_in.tech_active |=> main_setpoint_out == $past(override_in.tech_value))
        else $error("tech override lost");
    jog_wins_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        !override_in.tech_active && override_in.jog_active
        |=> main_setpoint_out == $past(override_in.jog_value)) else $error("jog override lost");
    main_analog_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        no_ov && msrc == SRC_ANALOG |=> main_setpoint_out == $past(sources_in.analog0))
        else $error("main not analog");
    extra_bus_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        xsrc == SRC_FIELDBUS |=> extra_setpoint_out == $past(sources_in.second_process_word))
        else $error("extra not fieldbus");
    main_pot_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        no_ov && msrc == SRC_POT |=> main_setpoint_out == pot_value_out)
        else $error("main not pot");
    main_fixed_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        no_ov && msrc == SRC_FIXED |=> main_setpoint_out == $past(sources_in.fixed_setpoint))
        else $error("main not fixed");
    pot_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        !pulse_enable_in && !$past(pulse_enable_in) && !cfg_all && !$past(cfg_all)
        && !(wr && paddr[5:2] == ADDR_SETVAL) && !$past(wr && paddr[5:2] == ADDR_SETVAL)
        && $stable(motor_on_in) && motor_on_in == $past(motor_on_in, 2)
        |=> $stable(pot_value_out)) else $error("pot moved without pulses");
endmodule
bind ssm_setpoint ssm_properties #(.SWITCH_CNT(SWITCH_CNT)) i_props (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .bin_in(bin_in),
    .motor_on_in(motor_on_in), .pulse_enable_in(pulse_enable_in), .sources_in(sources_in),
    .override_in(override_in), .main_setpoint_out(main_setpoint_out),
    .extra_setpoint_out(extra_setpoint_out), .pot_value_out(pot_value_out),
    .command_set_out(command_set_out));

// *** ssm_ctrl_model.sv ***
module ssm_ctrl_model (
    input wire logic ref_clk_in,
    input wire logic [7:0] bits_in,
    input wire logic [31:0] speed_in,
    output logic [7:0] bin_out,
    output ssm_pkg::ssm_sources_type sources_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import ssm_pkg::*;
    initial begin
        bin_out = 8'h00;
        sources_out = '0;
    end
    // Controller side: binary commands and one distinct word per source
    always @(posedge ref_clk_in) begin
        bin_out <= bits_in;
        sources_out.analog0 <= speed_in;
        sources_out.second_process_word <= speed_in + 32'h1;
        sources_out.fixed_setpoint <= speed_in + 32'h2;
        sources_out.setting_value <= speed_in + 32'h3;
    end
endmodule

// *** testbench.sv ***
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, s); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ssm_pkg::*;
    localparam int SW = 20;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [5:0] paddr = 6'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic [7:0] bits = 8'h00;
    logic [31:0] spd = 32'h100;
    logic [7:0] bin_in;
    logic motor_on_in = 1'b0;
    logic pulse_enable_in = 1'b1;
    ssm_sources_type sources_in;
    ssm_override_type override_in = '0;
    logic [31:0] main_setpoint_out;
    logic [31:0] extra_setpoint_out;
    logic [31:0] pot_value_out;
    logic command_set_out;
    logic [31:0] q;
    logic [11:0] codes [4] = '{SRC_ANALOG, SRC_FIELDBUS, SRC_FIXED, 12'h123};
    logic [3:0] ri [9] = '{ADDR_CFG, ADDR_RISE, ADDR_FALL, ADDR_START, ADDR_UPPER,
        ADDR_LOWER, ADDR_MAXSPD, ADDR_MAIN_SRC, ADDR_BIND};
    logic [31:0] rv [9] = '{32'h6, 32'h2710, 32'h2710, 32'h0, 32'h0, 32'h0, 32'h5DC,
        32'h41A, 32'h0};
    logic [3:0] pa [7] = '{ADDR_MAIN_SRC, ADDR_UPPER, ADDR_LOWER, ADDR_RISE, ADDR_FALL,
        ADDR_BIND, ADDR_CFG};
    logic [31:0] pd [7] = '{32'h41A, 32'h5, 32'hFFFFFFFB, 32'h1, 32'h1, 32'hCA9, 32'h14};
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int k;
    int j;
    ssm_ctrl_model i_ctrl (.ref_clk_in(ref_clk_in), .bits_in(bits), .speed_in(spd),
        .bin_out(bin_in), .sources_out(sources_in));
    ssm_setpoint #(.SWITCH_CNT(SW)) i_dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(), .bin_in(bin_in),
        .motor_on_in(motor_on_in), .pulse_enable_in(pulse_enable_in),
        .sources_in(sources_in), .override_in(override_in),
        .main_setpoint_out(main_setpoint_out), .extra_setpoint_out(extra_setpoint_out),
        .pot_value_out(pot_value_out), .command_set_out(command_set_out));
    always #4 ref_clk_in = ~ref_clk_in;
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            give_verdict();
        end
    end
    // One APB transfer; pready and read data are taken at the rising edge
    task xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {a, 2'b00};
        pwdata <= d;
        @(posedge ref_clk_in);
        penable <= 1'b1;
        do @(posedge ref_clk_in); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_n(input int n);
        repeat (n) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask
    task run(input logic [7:0] b, input int n);
        @(posedge ref_clk_in);
        bits <= b;
        wait_n(n);
    endtask
    task cycle_motor;
        @(posedge ref_clk_in);
        motor_on_in <= 1'b0;
        run(8'h00, 5);
        @(posedge ref_clk_in);
        motor_on_in <= 1'b1;
        wait_n(10);
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        for (k = 0; k < 9; k++) begin
            xfer(1'b0, ri[k], 32'h0);
            `CHK("reset value", rv[k], q)
        end
        for (k = 0; k < 4; k++) begin
            j = (k + 1) % 4;
            xfer(1'b1, ADDR_MAIN_SRC, {20'h0, codes[k]});
            xfer(1'b1, ADDR_EXTRA_SRC, {20'h0, codes[j]});
            wait_n(4);
            `CHK("main source", (k < 3) ? spd + 32'(k) : 32'h0, main_setpoint_out)
            `CHK("extra source", (j < 3) ? spd + 32'(j) : 32'h0, extra_setpoint_out)
        end
        override_in.tech_value <= 32'h11;
        override_in.jog_value <= 32'h22;
        override_in.panel_value <= 32'h33;
        for (k = 0; k < 3; k++) begin
            @(posedge ref_clk_in);
            override_in.tech_active <= (k == 0);
            override_in.jog_active <= (k < 2);
            override_in.panel_active <= 1'b1;
            wait_n(3);
            `CHK("override", 32'(17 * (k + 1)), main_setpoint_out)
        end
        override_in.panel_active <= 1'b0;
        xfer(1'b1, ADDR_CMD_SEL, 32'h3);
        bits <= 8'h08;
        k = 0;
        do begin
            @(negedge ref_clk_in);
            k++;
        end while (command_set_out !== 1'b1 && k < 60);
        `CHK("switch time", 1'b1, k >= SW && k <= SW + 6)
        for (k = 0; k < 7; k++) xfer(1'b1, pa[k], pd[k]);
        motor_on_in <= 1'b1;
        run(8'h02, 300);
        `CHK("rounded start", 32'h0, pot_value_out)
        run(8'h02, 1800);
        `CHK("pot top", 32'h5, pot_value_out)
        xfer(1'b1, ADDR_CFG, 32'h10);
        run(8'h04, 300);
        `CHK("pot falling", 1'b1, $signed(pot_value_out) > 0 && $signed(pot_value_out) < 5)
        run(8'h04, 2000);
        `CHK("pot bottom", 32'hFFFFFFFB, pot_value_out)
        `CHK("main from pot", 32'hFFFFFFFB, main_setpoint_out)
        run(8'h06, 200);
        `CHK("pot both", 32'hFFFFFFFB, pot_value_out)
        xfer(1'b1, ADDR_CFG, 32'h0);
        pulse_enable_in <= 1'b0;
        run(8'h02, 200);
        `CHK("pot no pulses", 32'hFFFFFFFB, pot_value_out)
        pulse_enable_in <= 1'b1;
        run(8'h12, 10);
        `CHK("auto jump", 32'h5, pot_value_out)
        xfer(1'b1, ADDR_START, 32'h2);
        cycle_motor();
        `CHK("start value", 32'h2, pot_value_out)
        xfer(1'b1, ADDR_CFG, 32'h1);
        run(8'h12, 10);
        cycle_motor();
        `CHK("kept value", 32'h5, pot_value_out)
        xfer(1'b0, ADDR_SETVAL, 32'h0);
        `CHK("setting value", spd + 32'h3, q)
        give_verdict();
    end
endmodule
